// ==== hdl/pin_select_params.svh ====
// Purpose: Offsets, field positions, reset values for the pin selector
// Assumes: Included by bare name wherever a constant is needed
// Notes: Definitions only
`ifndef PIN_SELECT_PARAMS_SVH
`define PIN_SELECT_PARAMS_SVH
`define PS_PIN_COUNT 8
`define PS_ADDR_WIDTH 16
`define PS_CFG_ADDR 16'hff8f
`define PS_CFG_RESET_CODE 4'h8
`define PS_CODE_MSB 3
`define PS_CODE_ALL_DIGITAL 4'h8
`define PS_CFG_UPPER_ZERO 4'h0
`define PS_PINS_NONE 8'h00
`define PS_PINS_ALL 8'hff
`endif

// ==== hdl/pin_select_pkg.sv ====
// Purpose: Shared types of the analog/digital pin selector
// Assumes: Constants live in pin_select_params.svh
// Notes: Types only
package pin_select_pkg;
   typedef enum logic {ST_IDLE, ST_WAIT} bus_state_t;
   typedef logic [3:0] boundary_code_t;
endpackage

// ==== hdl/pin_select_if.sv ====
// Purpose: Carries the boundary code to the decoder and its mask back
// Assumes: One decoder, one user
// Notes: Mask bit set means the pin is analog
`timescale 1ns/1ns
`include "pin_select_params.svh"
interface pin_select_if;
   pin_select_pkg::boundary_code_t code;
   logic [`PS_PIN_COUNT-1:0] analog_mask;
   modport decoder (input code, output analog_mask);
   modport user (output code, input analog_mask);
endinterface

// ==== hdl/pin_boundary_decode.sv ====
// Purpose: Turns the boundary code into a per-pin analog mask
// Assumes: Code arrives registered from the configuration register
// Notes: Purely combinational
`timescale 1ns/1ns
`include "pin_select_params.svh"
module pin_boundary_decode (
   pin_select_if.decoder sel_if
);
   logic prohibited;

   // Illegal codes fall back to all digital so no pin is left undefined
   assign prohibited = sel_if.code > `PS_CODE_ALL_DIGITAL;

   genvar i;
   generate
      for (i = 0; i < `PS_PIN_COUNT; i++) begin : g_pin
         // Pins below the boundary are digital, the rest analog
         assign sel_if.analog_mask[i] =
            !prohibited && (sel_if.code <= 4'(i));
      end
   endgenerate
endmodule

// ==== hdl/analog_digital_pin_select.sv ====
// Purpose: Pin-function configuration register and shared-pin routing
// Assumes: CPU holds a write while wait is shown; inputs synchronous
// Notes: Wait is registered, so it shows the cycle after the write
// Behaviour
// - Config register at FF8FH, eight bits, upper four read zero.
// - Any reset loads the register with 08H, all pins digital.
// - Both single-bit and whole-byte reads and writes are accepted.
// - The code routes each shared pin to analog or digital path.
// - Code 0 all analog, 1..7 lowest pins digital, 8 all digital.
// - Every write to the register inserts one wait cycle.
// - Segment function overrides the analog/digital code on a pin.
`timescale 1ns/1ns
`include "pin_select_params.svh"
module analog_digital_pin_select (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic [`PS_ADDR_WIDTH-1:0] cpu_addr_in,
   input wire logic cpu_wr_in,
   input wire logic cpu_rd_in,
   input wire logic cpu_bit_op_in,
   input wire logic [2:0] cpu_bit_sel_in,
   input wire logic [7:0] cpu_wdata_in,
   input wire logic [`PS_PIN_COUNT-1:0] port_two_direction_reg_in,
   input wire logic [`PS_PIN_COUNT-1:0] port_two_segment_function_reg_in,
   input wire logic [2:0] converter_channel_select_in,
   output logic [7:0] cpu_rdata_out,
   output logic cpu_wait_out,
   output logic [`PS_PIN_COUNT-1:0] pin_analog_out,
   output logic [`PS_PIN_COUNT-1:0] pin_digital_out,
   output logic [`PS_PIN_COUNT-1:0] pin_segment_out,
   output logic direction_conflict_out,
   output logic channel_conflict_out
);
   pin_select_pkg::bus_state_t state_ff, nxt_state;
   pin_select_pkg::boundary_code_t code_ff, nxt_code, new_code;
   logic wait_ff, nxt_wait;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [7:0] merged;
   logic cfg_hit, wr_take;
   logic [`PS_PIN_COUNT-1:0] analog_ff, nxt_analog;
   logic [`PS_PIN_COUNT-1:0] digital_ff, nxt_digital;
   logic [`PS_PIN_COUNT-1:0] segment_ff, nxt_segment;
   logic dir_conf_ff, nxt_dir_conf, chan_conf_ff, nxt_chan_conf;

   pin_select_if sel_if ();

   pin_boundary_decode u_decode (
      .sel_if(sel_if)
   );

   assign sel_if.code = code_ff;

   assign cfg_hit = cpu_addr_in == `PS_CFG_ADDR;
   // A held write during the wait cycle must not be taken twice
   assign wr_take = cpu_wr_in && cfg_hit &&
      (state_ff == pin_select_pkg::ST_IDLE);

   // Bit writes merge into the byte image; upper bits stay zero
   always_comb begin
      merged = {`PS_CFG_UPPER_ZERO, code_ff};
      if (cpu_bit_op_in) begin
         merged[cpu_bit_sel_in] = cpu_wdata_in[0];
         new_code = merged[`PS_CODE_MSB:0];
      end else begin
         new_code = cpu_wdata_in[`PS_CODE_MSB:0];
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_code = code_ff;
      nxt_wait = 1'b0;
      unique case (state_ff)
         pin_select_pkg::ST_IDLE: begin
            if (wr_take) begin
               nxt_code = new_code;
               nxt_state = pin_select_pkg::ST_WAIT;
               nxt_wait = 1'b1;
            end
         end
         pin_select_pkg::ST_WAIT: begin
            nxt_state = pin_select_pkg::ST_IDLE;
         end
      endcase
      // Unselected reads return zero so the data bus can be OR-merged
      if (cpu_rd_in && cfg_hit) begin
         nxt_rdata = {`PS_CFG_UPPER_ZERO, code_ff};
      end else begin
         nxt_rdata = `PS_PINS_NONE;
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_ff <= pin_select_pkg::ST_IDLE;
         code_ff <= `PS_CFG_RESET_CODE;
         wait_ff <= 1'b0;
         rdata_ff <= `PS_PINS_NONE;
      end else begin
         state_ff <= nxt_state;
         code_ff <= nxt_code;
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end

   // Routing: segment first, then the analog/digital boundary
   always_comb begin
      nxt_segment = port_two_segment_function_reg_in;
      nxt_analog = sel_if.analog_mask &
         ~port_two_segment_function_reg_in;
      nxt_digital = ~sel_if.analog_mask &
         ~port_two_segment_function_reg_in;
      // Flags only report; software keeps these settings right
      nxt_dir_conf = |(nxt_analog & ~port_two_direction_reg_in);
      nxt_chan_conf =
         !sel_if.analog_mask[converter_channel_select_in];
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         analog_ff <= `PS_PINS_NONE;
         digital_ff <= `PS_PINS_ALL;
         segment_ff <= `PS_PINS_NONE;
         dir_conf_ff <= 1'b0;
         chan_conf_ff <= 1'b0;
      end else begin
         analog_ff <= nxt_analog;
         digital_ff <= nxt_digital;
         segment_ff <= nxt_segment;
         dir_conf_ff <= nxt_dir_conf;
         chan_conf_ff <= nxt_chan_conf;
      end
   end

   assign cpu_rdata_out = rdata_ff;
   assign cpu_wait_out = wait_ff;
   assign pin_analog_out = analog_ff;
   assign pin_digital_out = digital_ff;
   assign pin_segment_out = segment_ff;
   assign direction_conflict_out = dir_conf_ff;
   assign channel_conflict_out = chan_conf_ff;

   // Independent model of the boundary, read only by assertions
   logic [`PS_PIN_COUNT-1:0] exp_mask;
   assign exp_mask = (code_ff <= `PS_CODE_ALL_DIGITAL) ?
      8'(`PS_PINS_ALL << code_ff) : `PS_PINS_NONE;
   // Flag models, so the flag checks do not reuse the routing logic
   logic exp_dir_conf, exp_chan_conf;
   assign exp_dir_conf = |(exp_mask & ~port_two_segment_function_reg_in &
      ~port_two_direction_reg_in);
   assign exp_chan_conf = !exp_mask[converter_channel_select_in];

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!reset_n_in);

   reset_value_a: assert property (
      $rose(reset_n_in) |-> code_ff == `PS_CFG_RESET_CODE &&
         pin_digital_out == `PS_PINS_ALL)
      else $error("config not at reset value after reset");

   byte_write_a: assert property (
      wr_take && !cpu_bit_op_in |=>
         code_ff == $past(cpu_wdata_in[`PS_CODE_MSB:0]))
      else $error("byte write not stored");

   bit_write_a: assert property (
      wr_take && cpu_bit_op_in && !cpu_bit_sel_in[2] |=>
         code_ff[$past(cpu_bit_sel_in[1:0])] == $past(cpu_wdata_in[0]))
      else $error("bit write not stored");

   read_back_a: assert property (
      cpu_rd_in && cfg_hit |=> cpu_rdata_out ==
         {`PS_CFG_UPPER_ZERO, $past(code_ff)})
      else $error("read back wrong or upper bits set");

   wait_insert_a: assert property (
      wr_take |=> cpu_wait_out ##1 !cpu_wait_out)
      else $error("write did not insert exactly one wait");

   boundary_map_a: assert property (
      1'b1 |=> pin_analog_out ==
         ($past(exp_mask) & ~$past(port_two_segment_function_reg_in)))
      else $error("analog mask does not match code");

   segment_wins_a: assert property (
      1'b1 |=> pin_segment_out ==
         $past(port_two_segment_function_reg_in) &&
         ((pin_analog_out | pin_digital_out) & pin_segment_out) == 8'h00 &&
         (pin_analog_out | pin_digital_out | pin_segment_out) == 8'hff)
      else $error("segment override or exclusivity broken");

   prohibited_code_a: assert property (
      code_ff > `PS_CODE_ALL_DIGITAL |=> pin_analog_out == 8'h00 &&
         pin_digital_out == ~$past(port_two_segment_function_reg_in))
      else $error("prohibited code not all digital");

   pin_route_a: assert property (
      $changed(code_ff) && code_ff == 4'h0 &&
         port_two_segment_function_reg_in == 8'h00 |=>
         pin_analog_out == 8'hff && pin_digital_out == 8'h00)
      else $error("code zero did not make all pins analog");

   direction_flag_a: assert property (
      1'b1 |=> direction_conflict_out == $past(exp_dir_conf))
      else $error("direction conflict flag wrong");

   channel_flag_a: assert property (
      1'b1 |=> channel_conflict_out == $past(exp_chan_conf))
      else $error("channel conflict flag wrong");

   idle_read_a: assert property (
      !(cpu_rd_in && cfg_hit) |=> cpu_rdata_out == 8'h00)
      else $error("read data not zero without a register read");

   byte_write_c: cover property (wr_take && !cpu_bit_op_in);
   bit_write_c: cover property (wr_take && cpu_bit_op_in);
   prohibited_c: cover property (code_ff > `PS_CODE_ALL_DIGITAL);
   segment_c: cover property (|port_two_segment_function_reg_in &&
      code_ff == 4'h0);
   read_back_c: cover property (cpu_rd_in && cfg_hit);
endmodule

// ==== verif/cpu_bus_model.sv ====
// Purpose: CPU side of the data bus for the pin selector
// Assumes: One access at a time, driven 1 ns after a rising edge
// Notes: Idle address and data show the inverse of the last value
`timescale 1ns/1ns
module cpu_bus_model (
   input wire logic ref_clk_in,
   input wire logic cpu_wait_in,
   input wire logic [7:0] cpu_rdata_in,
   output logic [15:0] cpu_addr_out,
   output logic cpu_wr_out,
   output logic cpu_rd_out,
   output logic cpu_bit_op_out,
   output logic [2:0] cpu_bit_sel_out,
   output logic [7:0] cpu_wdata_out
);
   initial begin
      cpu_addr_out = 16'h0000;
      cpu_wr_out = 1'b0;
      cpu_rd_out = 1'b0;
      cpu_bit_op_out = 1'b0;
      cpu_bit_sel_out = 3'h0;
      cpu_wdata_out = 8'h00;
   end
   // Single clock always runs, so the wait can always end
   task automatic write(input logic [15:0] a, input logic b,
      input logic [2:0] s, input logic [7:0] d,
      output logic w1, output logic w2);
      @(posedge ref_clk_in) #1;
      cpu_addr_out = a;
      cpu_bit_op_out = b;
      cpu_bit_sel_out = s;
      cpu_wdata_out = d;
      cpu_wr_out = 1'b1;
      @(posedge ref_clk_in) #1;
      w1 = cpu_wait_in;
      // Held through the wait cycle, as a stalled CPU would
      @(posedge ref_clk_in) #1;
      w2 = cpu_wait_in;
      cpu_wr_out = 1'b0;
      cpu_addr_out = ~cpu_addr_out;
      cpu_wdata_out = ~cpu_wdata_out;
      cpu_bit_sel_out = ~cpu_bit_sel_out;
   endtask
   task automatic read(input logic [15:0] a, output logic [7:0] d);
      @(posedge ref_clk_in) #1;
      cpu_addr_out = a;
      cpu_rd_out = 1'b1;
      @(posedge ref_clk_in) #1;
      d = cpu_rdata_in;
      cpu_rd_out = 1'b0;
      cpu_addr_out = ~cpu_addr_out;
   endtask
endmodule

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench of the analog/digital pin selector
// Assumes: Partner model issues every bus cycle
// Notes: Pins are checked only after the routing has settled
`timescale 1ns/1ns
`include "pin_select_params.svh"
module tb_top;
   logic ref_clk_in, reset_n_in, wr, rd, bop, wt, w1, w2, dc, cc;
   logic [15:0] addr;
   logic [2:0] bsel, chan;
   logic [7:0] wd, rdat, rv, dir, seg, ana, dig, sgo;
   int fail_count = 0, n_compared = 0, cycles = 0;
   logic [2:0] bs[3] = '{3'h0, 3'h3, 3'h5};
   logic bd[3] = '{1'b1, 1'b0, 1'b1};
   logic [3:0] be[3] = '{4'h9, 4'h1, 4'h1};
   analog_digital_pin_select dut (.ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in), .cpu_addr_in(addr), .cpu_wr_in(wr),
      .cpu_rd_in(rd), .cpu_bit_op_in(bop), .cpu_bit_sel_in(bsel),
      .cpu_wdata_in(wd), .port_two_direction_reg_in(dir),
      .port_two_segment_function_reg_in(seg),
      .converter_channel_select_in(chan), .cpu_rdata_out(rdat),
      .cpu_wait_out(wt), .pin_analog_out(ana), .pin_digital_out(dig),
      .pin_segment_out(sgo), .direction_conflict_out(dc),
      .channel_conflict_out(cc));
   cpu_bus_model cpu (.ref_clk_in(ref_clk_in), .cpu_wait_in(wt),
      .cpu_rdata_in(rdat), .cpu_addr_out(addr), .cpu_wr_out(wr),
      .cpu_rd_out(rd), .cpu_bit_op_out(bop), .cpu_bit_sel_out(bsel),
      .cpu_wdata_out(wd));
   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   function automatic logic [7:0] mask_of(input logic [3:0] c);
      logic [7:0] m;
      for (int i = 0; i < 8; i++) m[i] = (c <= 4'h8) && (i >= c);
      return m;
   endfunction
   task automatic check(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic pins_ok(input logic [3:0] c);
      logic [7:0] m;
      m = mask_of(c);
      check("analog", ana, m & ~seg);
      check("digital", dig, ~m & ~seg);
      check("segment", sgo, seg);
      check("dirconf", {7'h0, dc}, {7'h0, |(m & ~seg & ~dir)});
      check("chanconf", {7'h0, cc}, {7'h0, !m[chan]});
   endtask
   task automatic do_reset();
      reset_n_in = 1'b0;
      repeat (16) @(posedge ref_clk_in);
      #1 reset_n_in = 1'b1;
   endtask
   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles > 4000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      dir = 8'hff;
      seg = 8'h00;
      chan = 3'h7;
      void'($urandom(32'h6c73));
      do_reset();
      cpu.read(`PS_CFG_ADDR, rv);
      check("reset_rd", rv, 8'h08);
      pins_ok(4'h8);
      $display("test reset values done");
      for (int c = 0; c < 16; c++) begin
         seg = (c % 4 == 3) ? 8'($urandom) : 8'h00;
         dir = 8'($urandom);
         chan = 3'($urandom);
         cpu.write(`PS_CFG_ADDR, 1'b0, 3'h0, {4'($urandom), 4'(c)}, w1, w2);
         check("wait_on", {7'h0, w1}, 8'h01);
         check("wait_off", {7'h0, w2}, 8'h00);
         cpu.read(`PS_CFG_ADDR, rv);
         check("byte_rd", rv, {4'h0, 4'(c)});
         pins_ok(4'(c));
      end
      $display("test code sweep done");
      // Segment over an all-analog code, the override corner
      seg = 8'h3c;
      cpu.write(`PS_CFG_ADDR, 1'b0, 3'h0, 8'h00, w1, w2);
      cpu.read(`PS_CFG_ADDR, rv);
      check("seg_rd", rv, 8'h00);
      pins_ok(4'h0);
      seg = 8'h00;
      $display("test segment override done");
      cpu.write(`PS_CFG_ADDR, 1'b0, 3'h0, 8'h08, w1, w2);
      for (int i = 0; i < 3; i++) begin
         cpu.write(`PS_CFG_ADDR, 1'b1, bs[i], {7'h0, bd[i]}, w1, w2);
         check("bit_wait", {7'h0, w1}, 8'h01);
         cpu.read(`PS_CFG_ADDR, rv);
         check("bit_rd", rv, {4'h0, be[i]});
         pins_ok(be[i]);
      end
      $display("test bit writes done");
      cpu.write(16'hff8e, 1'b0, 3'h0, 8'h05, w1, w2);
      check("other_wait", {7'h0, w1}, 8'h00);
      cpu.read(16'hff8e, rv);
      check("other_rd", rv, 8'h00);
      cpu.read(`PS_CFG_ADDR, rv);
      check("kept_rd", rv, 8'h01);
      $display("test other address done");
      cpu.write(`PS_CFG_ADDR, 1'b0, 3'h0, 8'h03, w1, w2);
      do_reset();
      cpu.read(`PS_CFG_ADDR, rv);
      check("rerst_rd", rv, 8'h08);
      pins_ok(4'h8);
      $display("test second reset done");
      end_of_test();
   end
endmodule
